// ### rtl/svd_detect.v
// svd_detect.v: supply high/low voltage detector control with avalon-mm slave
// assumes: analog comparator outputs arrive asynchronously on pins; a separate
// free-running settle timer pulse is not available, so a counter on i_clk_sys
// sized by a time constant stands in for the clock-independent interval.
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "svd_consts.vh"

module svd_detect #(
  parameter SETTLE_CYC = `SVD_SETTLE_CYC
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_rst_n,
  // avalon-mm slave
  input wire [3:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // analog side
  input wire i_cmp_above,
  input wire i_cmp_below,
  input wire i_sleep,
  output wire o_detector_enable,
  output wire [3:0] o_trip_level_select,
  output wire o_use_external_trip_input,
  // interrupt and wake
  output wire o_irq,
  output wire o_wake
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg [1:0] rst_sync;
  wire rst_n;

  // two stage release of the async reset
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ------------------------------------------------------------
  // comparator input synchronisers
  // ------------------------------------------------------------
  reg [2:0] above_sync;
  reg [2:0] below_sync;
  reg above;
  reg below;

  // three flops; a level counts once stages two and three agree
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      above_sync <= 3'h0;
      below_sync <= 3'h0;
      above <= 1'b0;
      below <= 1'b0;
    end else begin
      above_sync <= {above_sync[1:0], i_cmp_above};
      below_sync <= {below_sync[1:0], i_cmp_below};
      if (above_sync[2] == above_sync[1]) begin
        above <= above_sync[2];
      end
      if (below_sync[2] == below_sync[1]) begin
        below <= below_sync[2];
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg trip_direction;
  reg detector_enable;
  reg [3:0] trip_level_select;
  reg reference_stable_flag;
  reg voltage_event_flag;
  reg voltage_event_irq_enable;
  reg global_irq_enable;
  reg [31:0] settle_cnt;
  wire wr_ctrl;
  wire wr_flag;
  wire trip_hit;
  wire event_set;
  wire stop_req;
  wire rd_first;
  reg rd_ack;

  assign wr_ctrl = i_avs_write && (i_avs_address == `SVD_ADDR_CTRL);
  assign wr_flag = i_avs_write && (i_avs_address == `SVD_ADDR_FLAG);

  assign trip_hit = trip_direction ? above : below;
  assign event_set = detector_enable && reference_stable_flag && trip_hit;
  // control write that turns the detector off
  assign stop_req = wr_ctrl && !i_avs_writedata[`SVD_BIT_EN];

  // bus writes to the control, irq enable and global enable registers
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trip_direction <= 1'b0;
      detector_enable <= 1'b0;
      trip_level_select <= `SVD_LEVEL_RESET;
      voltage_event_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else if (i_avs_write) begin
      case (i_avs_address)
        `SVD_ADDR_CTRL: begin
          trip_direction <= i_avs_writedata[`SVD_BIT_DIR];
          detector_enable <= i_avs_writedata[`SVD_BIT_EN];
          trip_level_select <= i_avs_writedata[`SVD_LEVEL_MSB:0];
        end
        `SVD_ADDR_IEN: voltage_event_irq_enable <= i_avs_writedata[`SVD_BIT_EVENT];
        `SVD_ADDR_GIE: global_irq_enable <= i_avs_writedata[`SVD_BIT_GIE];
        default: begin
        end
      endcase
    end
  end

  // settle timed as fixed interval; stable after count
  // drop on disable, already at the edge that writes enable low, so
  // the interrupt cannot outlive the enable bit by a cycle
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 32'h0;
      reference_stable_flag <= 1'b0;
    end else if (!detector_enable || stop_req) begin
      settle_cnt <= 32'h0;
      reference_stable_flag <= 1'b0;
    end else if (!reference_stable_flag) begin
      if (settle_cnt >= SETTLE_CYC - 1) begin
        reference_stable_flag <= 1'b1;
      end else begin
        settle_cnt <= settle_cnt + 32'h1;
      end
    end
  end

  // set on crossing; sticky until cleared, set wins over clear
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      voltage_event_flag <= 1'b0;
    end else if (event_set) begin
      voltage_event_flag <= 1'b1;
    end else if (wr_flag) begin
      voltage_event_flag <= i_avs_writedata[`SVD_BIT_EVENT];
    end
  end

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // a read is held off for one cycle: the first edge loads the read data
  // flop, the second edge accepts the read with that data standing on the bus
  assign rd_first = i_avs_read && !rd_ack;

  // marks the second cycle of a read; a write never waits
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= rd_first;
    end
  end

  // ------------------------------------------------------------
  // read data and outputs
  // ------------------------------------------------------------
  // registered read data; unmapped reads return zero
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (rd_first) begin
      case (i_avs_address)
        `SVD_ADDR_CTRL: o_avs_readdata <= {24'h0, trip_direction, 1'b0,
          reference_stable_flag, detector_enable, trip_level_select};
        `SVD_ADDR_FLAG: o_avs_readdata <= {29'h0, voltage_event_flag, 2'h0};
        `SVD_ADDR_IEN: o_avs_readdata <= {29'h0, voltage_event_irq_enable, 2'h0};
        `SVD_ADDR_GIE: o_avs_readdata <= {24'h0, global_irq_enable, 7'h0};
        default: o_avs_readdata <= 32'h0;
      endcase
    end
  end

  // writes complete at once; reads wait for the data flop to load
  assign o_avs_waitrequest = rd_first;

  assign o_detector_enable = detector_enable;
  assign o_trip_level_select = trip_level_select;
  assign o_use_external_trip_input = (trip_level_select == `SVD_LEVEL_EXT);
  // irq needs both enables and stable reference
  assign o_irq = voltage_event_flag && voltage_event_irq_enable && global_irq_enable
    && reference_stable_flag;
  // wake from sleep on flag, independent of global enable
  assign o_wake = i_sleep && voltage_event_flag && voltage_event_irq_enable;

endmodule

// ### rtl/svd_consts.vh
// svd_consts.vh: offsets, fields, reset values and timing of the supply detector
// assumes: included by the detector design files by bare name
`ifndef SVD_CONSTS_VH
`define SVD_CONSTS_VH

// ------------------------------------------------------------
// register byte addresses (word aligned)
// ------------------------------------------------------------
`define SVD_ADDR_CTRL 4'h0
`define SVD_ADDR_FLAG 4'h4
`define SVD_ADDR_IEN 4'h8
`define SVD_ADDR_GIE 4'hc

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define SVD_BIT_DIR 7
`define SVD_BIT_STABLE 5
`define SVD_BIT_EN 4
`define SVD_LEVEL_MSB 3
`define SVD_LEVEL_EXT 4'hf
`define SVD_CTRL_RESET 8'h05
`define SVD_LEVEL_RESET 4'h5
`define SVD_CTRL_WMASK 8'h9f

// ------------------------------------------------------------
// flag / enable bit positions
// ------------------------------------------------------------
`define SVD_BIT_EVENT 2
`define SVD_BIT_GIE 7

// ------------------------------------------------------------
// reference settle time
// ------------------------------------------------------------
`define SVD_SETTLE_NS 20000
`define SVD_CLK_NS 10
`define SVD_SETTLE_CYC ((`SVD_SETTLE_NS + `SVD_CLK_NS - 1) / `SVD_CLK_NS)

`endif

// ### bench/svd_detect_props.sv
// svd_detect_props.sv: port-level checks for the supply detector
// assumes: bound to every svd_detect instance, one clock domain
`timescale 1ns/10ps
module svd_detect_props #(parameter SETTLE_CYC = 2000) (
  // watched ports
  input wire i_clk_sys, i_rst_n, i_avs_read, i_avs_write, i_sleep,
  input wire [3:0] i_avs_address,
  input wire [31:0] i_avs_writedata, o_avs_readdata,
  input wire o_detector_enable, o_use_external_trip_input, o_irq, o_wake,
  input wire [3:0] o_trip_level_select
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // cycles spent enabled, saturating at the settle count
  int en_cnt;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) en_cnt <= 0;
    else if (!o_detector_enable) en_cnt <= 0;
    else if (en_cnt < SETTLE_CYC) en_cnt <= en_cnt + 1;
  end
  irq_needs_en_a: assert property (o_irq |-> o_detector_enable)
    else $error("irq while detector off");
  ext_select_a: assert property (o_use_external_trip_input == (o_trip_level_select == 4'hf))
    else $error("external select wrong");
  level_write_a:
    assert property (i_avs_write && i_avs_address == 4'h0 |=> o_trip_level_select ==
      $past(i_avs_writedata[3:0]) && o_detector_enable == $past(i_avs_writedata[4]))
    else $error("control write not applied");
  settle_irq_a: assert property ($rose(o_irq) |-> en_cnt >= SETTLE_CYC - 1)
    else $error("irq before settle time");
  disable_irq_a: assert property ($fell(o_detector_enable) |=> !o_irq)
    else $error("irq after disable");
  sleep_wake_a: assert property (o_irq && i_sleep |-> o_wake)
    else $error("no wake on event in sleep");
  hold_wake_a: assert property ($fell(o_wake) && i_sleep && $past(i_sleep) |-> $past(i_avs_write))
    else $error("event dropped without clear");
  unmapped_rd_a: assert property (i_avs_read && i_avs_address == 4'h2 |=> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  cover property ($rose(o_irq));
  cover property ($rose(o_wake));
  cover property ($rose(o_use_external_trip_input));
endmodule
bind svd_detect svd_detect_props #(.SETTLE_CYC(SETTLE_CYC)) chk_u (.i_clk_sys, .i_rst_n,
  .i_avs_read, .i_avs_write, .i_sleep, .i_avs_address, .i_avs_writedata, .o_avs_readdata,
  .o_detector_enable, .o_use_external_trip_input, .o_irq, .o_wake, .o_trip_level_select);

// ### bench/tb.sv
// tb.sv: self-checking bench for the supply detector
// assumes: settle count shortened to 24 cycles
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, above = 0, below = 0, sleep = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata = 32'h0;
  wire [31:0] dout;
  wire [3:0] lvl;
  wire wq, en, ext, irq, wake;
  int bad_count = 0, checks = 0;
  svd_detect #(.SETTLE_CYC(24)) dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(dout),
    .o_avs_waitrequest(wq), .i_cmp_above(above), .i_cmp_below(below), .i_sleep(sleep),
    .o_detector_enable(en), .o_trip_level_select(lvl), .o_use_external_trip_input(ext),
    .o_irq(irq), .o_wake(wake));
  // ----
  // clock, compare, bus cycle
  // ----
  initial forever #5 clk = ~clk;
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // called just after an edge; request held until waitrequest is seen low,
  // read data taken at that same edge, one idle edge before returning
  task bus(input [3:0] a, input w, input [31:0] d);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    do @(posedge clk); while (wq !== 1'b0);
    rdata = dout;
    wr <= 0;
    rd <= 0;
    @(posedge clk);
  endtask
  // comparator held a few cycles, then settle time for the sync
  task pulse(input hi);
    @(posedge clk);
    if (hi) above <= 1; else below <= 1;
    repeat (4) @(posedge clk);
    above <= 0; below <= 0;
    repeat (6) @(posedge clk);
  endtask
  // ----
  // scenarios
  // ----
  task t_reset;
    bus(4'h0, 0, 0);
    chk("ctrl", rdata, 32'h5);
    chk("level", {28'h0, lvl}, 32'h5);
  endtask
  task t_settle;
    bus(4'h0, 1, 32'h03); // level and direction first
    bus(4'h0, 1, 32'h13); // then enable
    chk("enable on", en, 1);
    pulse(0);
    bus(4'h4, 0, 0);
    chk("early flag", rdata, 32'h0);
    bus(4'h0, 0, 0);
    chk("ctrl unstable", rdata, 32'h13);
    bus(4'h4, 1, 0); // clear stale flag
    bus(4'h8, 1, 32'h4); // then irq enables
    bus(4'hc, 1, 32'h80);
    repeat (24) @(posedge clk);
    bus(4'h0, 0, 0);
    chk("ctrl stable", rdata, 32'h33);
  endtask
  task t_dir(input [31:0] c, input wrong);
    bus(4'h0, 1, c);
    pulse(wrong);
    bus(4'h4, 0, 0);
    chk("wrong way", rdata, 32'h0);
    pulse(!wrong);
    bus(4'h4, 0, 0);
    chk("event flag", rdata, 32'h4);
    chk("irq", irq, 1);
  endtask
  task t_sleep;
    sleep <= 1;
    bus(4'hc, 1, 0);
    chk("irq masked", irq, 0);
    chk("wake", wake, 1);
    bus(4'h4, 1, 0);
    chk("wake cleared", wake, 0);
    sleep <= 0;
  endtask
  task t_off;
    bus(4'h0, 1, 32'h0f);
    chk("external", ext, 1);
    chk("enable off", en, 0);
    bus(4'h0, 0, 0);
    chk("ctrl off", rdata, 32'h0f);
    bus(4'h2, 0, 0);
    chk("unmapped", rdata, 32'h0);
  endtask
  // mid-run reset with the detector armed and the flag set by software
  task t_rerst;
    bus(4'h0, 1, 32'h93);
    bus(4'h4, 1, 32'h4);
    bus(4'h4, 0, 0);
    chk("soft flag", rdata, 32'h4);
    rst_n <= 0;
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    chk("enable reset", en, 0);
    bus(4'h0, 0, 0);
    chk("ctrl reset", rdata, 32'h5);
    bus(4'h4, 0, 0);
    chk("flag reset", rdata, 32'h0);
  endtask
  task final_report;
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1;
    repeat (3) @(posedge clk);
    t_reset;
    t_settle;
    t_dir(32'h13, 1);
    bus(4'h4, 1, 0);
    t_dir(32'h93, 0);
    t_sleep;
    t_off;
    t_rerst;
    final_report;
  end
  initial begin
    #100000;
    bad_count++;
    final_report;
  end
endmodule
